// ### design/smd_cmd_map.vh
// constants for the stepper stop and home command decoder
// Function
// - switch-release byte: 1001, action bit3, 01, sense bit0
// - switch-release moves at minimum speed, sense picks direction
// - switch opens: clear or save position, halt instantly
// - use fixed low speed when minimum too low
// - busy low until switch opens and motor rests
// - return-to-zero is absolute go-to with zero target
// - return-to-zero only when idle, else reject flag
// - return-to-saved is absolute go-to to saved position
// - return-to-saved only when idle, else reject flag
// - clear-position loads zero into position counter
// - full reinit only while bridges are off
// - ramped halt decelerates with deceleration value
// - ramped halt with bridges off re-enables, no motion
// - instant halt stops motor without ramp
// - instant halt with bridges off re-enables, no motion
// - halts and bridge-offs always accepted, never rejected
// - halts and bridge-offs keep busy low until rest
// - ramped bridge-off: ramp down, disable bridges, flag
// - ramped bridge-off at rest disables bridges directly
// - instant bridge-off disables bridges at once, flag
// - status fetch returns status in two following bytes
// - status fetch clears warnings, error; bridges flag kept
`ifndef SMD_CMD_MAP_VH
`define SMD_CMD_MAP_VH
`define SMD_OP_RETURN_TO_ZERO 8'h70
`define SMD_OP_RETURN_TO_SAVED 8'h78
`define SMD_OP_CLEAR_POSITION 8'hd8
`define SMD_OP_FULL_REINIT 8'hc0
`define SMD_OP_RAMPED_HALT 8'hb0
`define SMD_OP_INSTANT_HALT 8'hb8
`define SMD_OP_RAMPED_BRIDGE_OFF 8'ha0
`define SMD_OP_INSTANT_BRIDGE_OFF 8'ha8
`define SMD_OP_STATUS_FETCH 8'hd0
`define SMD_SEEK_HI_NIBBLE 4'h9
`define SMD_SEEK_FIXED_BITS 2'h1
`define SMD_SEEK_ACT_BIT 3
`define SMD_SEEK_DIR_BIT 0
`define SMD_SEEK_SPEED_FLOOR 32'd5
`define SMD_STATUS_W 16
`define SMD_BRIDGES_OFF_BIT 0
`define SMD_WARN_MASK 16'hfe00
`define SMD_MOT_IDLE 3'h0
`define SMD_MOT_SEEK 3'h1
`define SMD_MOT_ABSOLUTE_A 3'h2
`define SMD_MOT_RAMP 3'h3
`define SMD_MOT_RAMP_OFF 3'h4
`define SMD_MOT_HALT 3'h5
`define SMD_BYTE_LAST_BIT 3'h7
`define SMD_REPLY_BYTES 2'h2
`endif

// ### design/smd_cmd_decoder.v
// serial command decoder for stop, home and status commands
`timescale 1ns/1ps
`include "smd_cmd_map.vh"
module smd_cmd_decoder #(
  parameter POS_W = 22,
  parameter SPD_W = 20
) (
  // clock and reset
  input wire I_CLK,
  input wire I_RST,
  // serial link from host
  input wire I_CS_N,
  input wire I_SCK,
  input wire I_SDI,
  output wire O_SDO,
  output wire O_SDO_OE,
  // limit switch, closed low
  input wire I_SWITCH_N,
  // configuration
  input wire [SPD_W-1:0] I_MIN_SPEED,
  input wire [SPD_W-1:0] I_SPEED_FLOOR,
  input wire I_LOW_SPEED_OPT,
  input wire [SPD_W-1:0] I_DECEL,
  // motion engine
  input wire I_MOTOR_STOPPED,
  input wire I_TARGET_REACHED,
  input wire [`SMD_STATUS_W-1:0] I_WARN_SET,
  output reg O_RUN,
  output reg O_DIR,
  output reg O_ABSOLUTE_A,
  output reg [POS_W-1:0] O_TARGET,
  output reg [SPD_W-1:0] O_SPEED,
  output reg O_RAMP_DOWN,
  output reg [SPD_W-1:0] O_DECEL,
  output reg O_STOP_NOW,
  output reg O_REINIT,
  // position registers
  output reg [POS_W-1:0] O_POSITION,
  output reg [POS_W-1:0] O_SAVED,
  input wire I_POS_STEP,
  input wire I_POS_DIR,
  // bridges and status
  output reg O_BRIDGE_EN,
  output wire O_BUSY_N,
  output reg [`SMD_STATUS_W-1:0] O_STATUS,
  output reg O_CMD_REJECT,
  output reg O_ERR_STATE
);
  // synchronised link and switch
  // two flops per pin; only the second flop feeds any logic
  reg [1:0] cs_sync_reg;
  reg [1:0] sck_sync_reg;
  reg [1:0] sdi_sync_reg;
  reg [1:0] sw_sync_reg;
  reg sck_last_reg;
  reg sw_last_reg;
  always @(posedge I_CLK) begin
    if (I_RST) begin
      cs_sync_reg <= 2'h3;
      sck_sync_reg <= 2'h0;
      sdi_sync_reg <= 2'h0;
      sw_sync_reg <= 2'h3;
      sck_last_reg <= 1'b0;
      sw_last_reg <= 1'b1;
    end else begin
      cs_sync_reg <= {cs_sync_reg[0], I_CS_N};
      sck_sync_reg <= {sck_sync_reg[0], I_SCK};
      sdi_sync_reg <= {sdi_sync_reg[0], I_SDI};
      sw_sync_reg <= {sw_sync_reg[0], I_SWITCH_N};
      sck_last_reg <= sck_sync_reg[1];
      sw_last_reg <= sw_sync_reg[1];
    end
  end

  // edges of the synchronised link clock, only inside a frame
  wire cs_act = ~cs_sync_reg[1];
  wire sck_rise = cs_act & sck_sync_reg[1] & ~sck_last_reg;
  wire sck_fall = cs_act & ~sck_sync_reg[1] & sck_last_reg;
  wire sw_open = sw_sync_reg[1] & ~sw_last_reg;

  // byte shifter, msb first
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg byte_done_reg;
  reg [7:0] byte_reg;
  reg [7:0] tx_reg;
  reg [1:0] resp_left_reg;
  reg [`SMD_STATUS_W-1:0] resp_reg;
  wire [7:0] shift_next = {shift_reg[6:0], sdi_sync_reg[1]};
  always @(posedge I_CLK) begin
    if (I_RST) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      byte_done_reg <= 1'b0;
      byte_reg <= 8'h00;
    end else begin
      byte_done_reg <= 1'b0;
      // a deselect drops a partial byte
      if (!cs_act) begin
        bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        shift_reg <= shift_next;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        // eighth rising edge closes the byte
        if (bit_cnt_reg == `SMD_BYTE_LAST_BIT) begin
          byte_reg <= shift_next;
          byte_done_reg <= 1'b1;
        end
      end
    end
  end

  // reply bytes load on the falling edge that closes a byte, shift on the others
  // loading there keeps the first reply bit steady until the host samples it
  always @(posedge I_CLK) begin
    if (I_RST) begin
      tx_reg <= 8'h00;
    end else if (!cs_act) begin
      tx_reg <= 8'h00;
    end else if (sck_fall) begin
      if (bit_cnt_reg != 3'h0) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end else if (resp_left_reg == `SMD_REPLY_BYTES) begin
        tx_reg <= resp_reg[15:8];
      end else if (resp_left_reg == 2'h1) begin
        tx_reg <= resp_reg[7:0];
      end else begin
        tx_reg <= 8'h00;
      end
    end
  end
  assign O_SDO = tx_reg[7];
  // reply driver on for the whole selected frame
  assign O_SDO_OE = cs_act;

  // opcode classes
  wire opcode = (resp_left_reg == 2'h0) & byte_done_reg;
  wire is_seek = (byte_reg[7:4] == `SMD_SEEK_HI_NIBBLE) &
    (byte_reg[2:1] == `SMD_SEEK_FIXED_BITS);
  wire op_zero = opcode & (byte_reg == `SMD_OP_RETURN_TO_ZERO);
  wire op_saved = opcode & (byte_reg == `SMD_OP_RETURN_TO_SAVED);
  wire op_clear = opcode & (byte_reg == `SMD_OP_CLEAR_POSITION);
  wire op_reinit = opcode & (byte_reg == `SMD_OP_FULL_REINIT);
  wire op_rhalt = opcode & (byte_reg == `SMD_OP_RAMPED_HALT);
  wire op_ihalt = opcode & (byte_reg == `SMD_OP_INSTANT_HALT);
  wire op_roff = opcode & (byte_reg == `SMD_OP_RAMPED_BRIDGE_OFF);
  wire op_ioff = opcode & (byte_reg == `SMD_OP_INSTANT_BRIDGE_OFF);
  wire op_stat = opcode & (byte_reg == `SMD_OP_STATUS_FETCH);
  wire op_seek = opcode & is_seek;

  // motion state
  reg [2:0] mot_reg;
  reg [2:0] mot_next;
  reg seek_act_reg;
  // busy spans seek, go-to, ramps and the wait for rest after a stop
  wire busy = (mot_reg != `SMD_MOT_IDLE);
  assign O_BUSY_N = ~busy;
  wire floor_spd = (I_MIN_SPEED < I_SPEED_FLOOR) | I_LOW_SPEED_OPT;

  // next motion state
  always @* begin
    mot_next = mot_reg;
    case (mot_reg)
      `SMD_MOT_IDLE: begin
        mot_next = `SMD_MOT_IDLE;
      end
      `SMD_MOT_SEEK: begin
        // switch released: stop at once, stay busy until the engine rests
        if (sw_open) begin
          mot_next = I_MOTOR_STOPPED ? `SMD_MOT_IDLE : `SMD_MOT_HALT;
        end
      end
      `SMD_MOT_ABSOLUTE_A: begin
        if (I_TARGET_REACHED) begin
          mot_next = `SMD_MOT_IDLE;
        end
      end
      `SMD_MOT_RAMP, `SMD_MOT_RAMP_OFF, `SMD_MOT_HALT: begin
        if (I_MOTOR_STOPPED) begin
          mot_next = `SMD_MOT_IDLE;
        end
      end
      default: begin
        mot_next = `SMD_MOT_IDLE;
      end
    endcase
    // halts, bridge-offs and seeks accepted in any state; go-to only when idle
    if (op_ihalt || op_ioff) begin
      // no ramp, but busy still waits for rest; a halt that only re-enables stays idle
      if ((op_ihalt && !O_BRIDGE_EN) || I_MOTOR_STOPPED) begin
        mot_next = `SMD_MOT_IDLE;
      end else begin
        mot_next = `SMD_MOT_HALT;
      end
    end else if (op_rhalt) begin
      mot_next = (O_BRIDGE_EN && !I_MOTOR_STOPPED) ? `SMD_MOT_RAMP : `SMD_MOT_IDLE;
    end else if (op_roff) begin
      mot_next = (O_BRIDGE_EN && !I_MOTOR_STOPPED) ? `SMD_MOT_RAMP_OFF : `SMD_MOT_IDLE;
    end else if (op_seek) begin
      mot_next = `SMD_MOT_SEEK;
    end else if ((op_zero || op_saved) && !busy) begin
      mot_next = `SMD_MOT_ABSOLUTE_A;
    end else if (op_reinit && !O_BRIDGE_EN) begin
      mot_next = `SMD_MOT_IDLE;
    end
  end

  // motion, position and status registers
  always @(posedge I_CLK) begin
    if (I_RST) begin
      mot_reg <= `SMD_MOT_IDLE;
      seek_act_reg <= 1'b0;
      resp_left_reg <= 2'h0;
      resp_reg <= {`SMD_STATUS_W{1'b0}};
      O_RUN <= 1'b0;
      O_DIR <= 1'b0;
      O_ABSOLUTE_A <= 1'b0;
      O_TARGET <= {POS_W{1'b0}};
      O_SPEED <= {SPD_W{1'b0}};
      O_RAMP_DOWN <= 1'b0;
      O_DECEL <= {SPD_W{1'b0}};
      O_STOP_NOW <= 1'b0;
      O_REINIT <= 1'b0;
      O_POSITION <= {POS_W{1'b0}};
      O_SAVED <= {POS_W{1'b0}};
      O_BRIDGE_EN <= 1'b0;
      O_STATUS <= {{(`SMD_STATUS_W-1){1'b0}}, 1'b1};
      O_CMD_REJECT <= 1'b0;
      O_ERR_STATE <= 1'b0;
    end else begin
      mot_reg <= mot_next;
      O_ABSOLUTE_A <= 1'b0;
      O_STOP_NOW <= 1'b0;
      O_REINIT <= 1'b0;
      O_CMD_REJECT <= 1'b0;
      // position counter tracks engine steps
      if (I_POS_STEP) begin
        O_POSITION <= I_POS_DIR ? O_POSITION + 1'b1 : O_POSITION - 1'b1;
      end
      // response byte counting; a cut frame drops any pending reply
      if (!cs_act) begin
        resp_left_reg <= 2'h0;
      end else if (byte_done_reg && resp_left_reg != 2'h0) begin
        resp_left_reg <= resp_left_reg - 2'h1;
      end
      // warnings: set wins over clear
      O_STATUS <= (O_STATUS & ~(op_stat ? `SMD_WARN_MASK : {`SMD_STATUS_W{1'b0}})) |
        (I_WARN_SET & `SMD_WARN_MASK);
      O_STATUS[`SMD_BRIDGES_OFF_BIT] <= ~O_BRIDGE_EN;
      if (|(I_WARN_SET & `SMD_WARN_MASK)) begin
        O_ERR_STATE <= 1'b1;
      end else if (op_stat) begin
        O_ERR_STATE <= 1'b0;
      end
      // the reply holds the status as it stood before this edge's clears
      if (op_stat) begin
        resp_reg <= O_STATUS;
        resp_left_reg <= `SMD_REPLY_BYTES;
      end
      // seek at minimum or floor speed
      if (op_seek) begin
        seek_act_reg <= byte_reg[`SMD_SEEK_ACT_BIT];
        O_DIR <= byte_reg[`SMD_SEEK_DIR_BIT];
        O_SPEED <= floor_spd ? I_SPEED_FLOOR : I_MIN_SPEED;
        O_RUN <= 1'b1;
        O_RAMP_DOWN <= 1'b0;
      end
      if (mot_reg == `SMD_MOT_SEEK && sw_open) begin
        if (seek_act_reg) begin
          O_SAVED <= O_POSITION;
        end else begin
          O_POSITION <= {POS_W{1'b0}};
        end
        O_RUN <= 1'b0;
        O_STOP_NOW <= 1'b1;
      end
      // go-to commands, refused while busy and never queued
      if ((op_zero || op_saved) && !busy) begin
        O_TARGET <= op_zero ? {POS_W{1'b0}} : O_SAVED;
        O_ABSOLUTE_A <= 1'b1;
      end else if ((op_zero || op_saved) && busy) begin
        O_CMD_REJECT <= 1'b1;
      end
      if (op_clear) begin
        O_POSITION <= {POS_W{1'b0}};
      end
      // halts
      if (op_rhalt || op_ihalt) begin
        if (!O_BRIDGE_EN) begin
          O_BRIDGE_EN <= 1'b1;
        end else if (op_rhalt) begin
          // a motor already at rest has nothing to ramp down
          if (!I_MOTOR_STOPPED) begin
            O_RAMP_DOWN <= 1'b1;
            O_DECEL <= I_DECEL;
          end
        end else begin
          O_STOP_NOW <= 1'b1;
          O_RAMP_DOWN <= 1'b0;
        end
        O_RUN <= 1'b0;
      end
      if (op_roff) begin
        O_RUN <= 1'b0;
        if (I_MOTOR_STOPPED) begin
          O_BRIDGE_EN <= 1'b0;
        end else begin
          O_RAMP_DOWN <= 1'b1;
          O_DECEL <= I_DECEL;
        end
      end
      if (mot_reg == `SMD_MOT_RAMP_OFF && I_MOTOR_STOPPED) begin
        O_BRIDGE_EN <= 1'b0;
      end
      if (mot_next == `SMD_MOT_IDLE && (mot_reg == `SMD_MOT_RAMP || mot_reg == `SMD_MOT_RAMP_OFF)) begin
        O_RAMP_DOWN <= 1'b0;
      end
      if (op_ioff) begin
        O_RUN <= 1'b0;
        O_RAMP_DOWN <= 1'b0;
        O_STOP_NOW <= 1'b1;
        O_BRIDGE_EN <= 1'b0;
      end
      // full reinit only with bridges off
      if (op_reinit && !O_BRIDGE_EN) begin
        O_REINIT <= 1'b1;
        O_RUN <= 1'b0;
        O_POSITION <= {POS_W{1'b0}};
        O_SAVED <= {POS_W{1'b0}};
        O_TARGET <= {POS_W{1'b0}};
        O_SPEED <= {SPD_W{1'b0}};
        O_DECEL <= {SPD_W{1'b0}};
        O_RAMP_DOWN <= 1'b0;
        O_DIR <= 1'b0;
        O_ERR_STATE <= 1'b0;
        O_STATUS <= {{(`SMD_STATUS_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ### verification/smd_host_model.sv
// host side serial master model for the command decoder
`timescale 1ns/1ps
module smd_host_model (
  // serial link toward the device
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi,
  input wire logic i_sdo
);
  // link idles deselected, clock parked low
  initial begin
    o_cs_n = 1;
    o_sck = 0;
    o_sdi = 0;
  end
  // one frame: opcode then n reply bytes, msb first, data set while clock low
  task send(input logic [7:0] op, input int n, output logic [15:0] rx);
    logic [7:0] b;
    o_cs_n = 0;
    #80;
    for (int j = 0; j <= n; j++) begin
      b = (j == 0) ? op : 8'h00;
      for (int i = 7; i >= 0; i--) begin
        o_sdi = b[i];
        #80;
        o_sck = 1;
        rx = {rx[14:0], i_sdo};
        #80;
        o_sck = 0;
      end
    end
    #80;
    o_cs_n = 1;
    o_sdi = ~o_sdi; // released line shows no stale bit
  endtask
endmodule

// ### verification/smd_cmd_decoder_props.sv
// assertion checker for the command decoder ports
`timescale 1ns/1ps
module smd_cmd_decoder_props #(
  parameter POS_W = 22,
  parameter SPD_W = 20
) (
  // clock, reset, link
  input wire I_CLK,
  input wire I_RST,
  input wire I_CS_N,
  input wire O_SDO_OE,
  // speed setup
  input wire [SPD_W-1:0] I_MIN_SPEED,
  input wire [SPD_W-1:0] I_SPEED_FLOOR,
  input wire I_LOW_SPEED_OPT,
  // motion and status
  input wire O_RUN,
  input wire [SPD_W-1:0] O_SPEED,
  input wire O_ABSOLUTE_A,
  input wire O_STOP_NOW,
  input wire O_REINIT,
  input wire O_BRIDGE_EN,
  input wire O_BUSY_N,
  input wire [15:0] O_STATUS,
  input wire O_CMD_REJECT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // frame edges of the select line
  sequence s_sel_open;
    $fell(I_CS_N);
  endsequence
  sequence s_sel_close;
    $rose(I_CS_N);
  endsequence
  a_oe_on_select: assert property (s_sel_open |-> ##[1:4] O_SDO_OE)
    else $error("reply driver not enabled");
  a_oe_off_deselect: assert property (s_sel_close |-> ##[1:4] !O_SDO_OE)
    else $error("reply driver left on");
  a_reject_one_cycle: assert property (O_CMD_REJECT |=> !O_CMD_REJECT)
    else $error("reject pulse too long");
  a_reject_while_busy: assert property (O_CMD_REJECT |-> !$past(O_BUSY_N))
    else $error("reject while idle");
  a_absolute_a_when_idle: assert property (O_ABSOLUTE_A |-> $past(O_BUSY_N))
    else $error("go-to started while busy");
  a_stop_ends_run: assert property (O_STOP_NOW |-> ##[0:1] !O_RUN)
    else $error("run kept after instant stop");
  a_flag_mirrors_bridge: assert property (O_STATUS[0] == !$past(O_BRIDGE_EN))
    else $error("bridges off flag wrong");
  a_reinit_bridges_off: assert property (O_REINIT |-> !$past(O_BRIDGE_EN))
    else $error("reinit with bridges on");
  a_seek_speed_pick: assert property ($rose(O_RUN) |-> O_SPEED ==
    ((I_LOW_SPEED_OPT || I_MIN_SPEED < I_SPEED_FLOOR) ? I_SPEED_FLOOR : I_MIN_SPEED))
    else $error("seek speed wrong");
endmodule
bind smd_cmd_decoder smd_cmd_decoder_props #(.POS_W(POS_W), .SPD_W(SPD_W)) u_props (.I_CLK, .I_RST, .I_CS_N,
  .O_SDO_OE, .I_MIN_SPEED, .I_SPEED_FLOOR, .I_LOW_SPEED_OPT, .O_RUN, .O_SPEED, .O_ABSOLUTE_A, .O_STOP_NOW, .O_REINIT,
  .O_BRIDGE_EN, .O_BUSY_N, .O_STATUS, .O_CMD_REJECT);

// ### verification/smd_cmd_decoder_tb_top.sv
// testbench for the stepper stop and home command decoder
`timescale 1ns/1ps
module smd_cmd_decoder_tb_top;
  logic I_CLK = 0, I_RST = 1, I_SWITCH_N = 0, I_LOW_SPEED_OPT = 0, I_MOTOR_STOPPED = 1;
  logic I_TARGET_REACHED = 0, I_POS_STEP = 0, I_POS_DIR = 1;
  logic [19:0] I_MIN_SPEED = 0, I_SPEED_FLOOR = 0, I_DECEL = 0;
  logic [15:0] I_WARN_SET = 0, rx;
  wire I_CS_N, I_SCK, I_SDI, O_SDO, O_SDO_OE, O_RUN, O_DIR, O_ABSOLUTE_A, O_RAMP_DOWN, O_STOP_NOW, O_REINIT;
  wire O_BRIDGE_EN, O_BUSY_N, O_CMD_REJECT, O_ERR_STATE;
  wire [21:0] O_TARGET, O_POSITION, O_SAVED;
  wire [19:0] O_SPEED, O_DECEL;
  wire [15:0] O_STATUS;
  int err_total = 0, check_count = 0, cyc = 0, seed, n_rej = 0, n_absolute_a = 0, n_stop = 0, n_reinit = 0;
  int q_sel[$];
  logic [31:0] q_exp[$];
  string nm[17] = '{"run", "dir", "speed", "busy_n", "position", "saved", "target", "bridge_en", "status",
    "err_state", "rejects", "gotos", "stops", "reinits", "ramp_down", "decel", "reply"};
  smd_cmd_decoder u_smd_cmd_decoder (.I_CLK, .I_RST, .I_CS_N, .I_SCK, .I_SDI, .O_SDO, .O_SDO_OE, .I_SWITCH_N,
    .I_MIN_SPEED, .I_SPEED_FLOOR, .I_LOW_SPEED_OPT, .I_DECEL, .I_MOTOR_STOPPED, .I_TARGET_REACHED, .I_WARN_SET,
    .O_RUN, .O_DIR, .O_ABSOLUTE_A, .O_TARGET, .O_SPEED, .O_RAMP_DOWN, .O_DECEL, .O_STOP_NOW, .O_REINIT, .O_POSITION,
    .O_SAVED, .I_POS_STEP, .I_POS_DIR, .O_BRIDGE_EN, .O_BUSY_N, .O_STATUS, .O_CMD_REJECT, .O_ERR_STATE);
  smd_host_model u_smd_host_model (.o_cs_n(I_CS_N), .o_sck(I_SCK), .o_sdi(I_SDI), .i_sdo(O_SDO));
  // 50 MHz clock
  initial forever #10 I_CLK = ~I_CLK;
  task final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // pulse tallies and hang guard, sampled mid-cycle where pulses have settled
  always @(negedge I_CLK) begin
    cyc++;
    n_rej += (O_CMD_REJECT === 1'b1);
    n_absolute_a += (O_ABSOLUTE_A === 1'b1);
    n_stop += (O_STOP_NOW === 1'b1);
    n_reinit += (O_REINIT === 1'b1);
    if (cyc > 20000) begin
      err_total++;
      final_report();
    end
  end
  task chk(int s, logic [31:0] e);
    logic [31:0] v;
    case (s)
      0: v = O_RUN; 1: v = O_DIR; 2: v = O_SPEED; 3: v = O_BUSY_N; 4: v = O_POSITION; 5: v = O_SAVED;
      6: v = O_TARGET; 7: v = O_BRIDGE_EN; 8: v = O_STATUS; 9: v = O_ERR_STATE; 10: v = n_rej; 11: v = n_absolute_a;
      12: v = n_stop; 13: v = n_reinit; 14: v = O_RAMP_DOWN; 15: v = O_DECEL; default: v = rx;
    endcase
    check_count++;
    if (v !== e) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", nm[s], e, v);
    end
  endtask
  // oldest note against what the outputs show now
  always @(negedge I_CLK) if (q_sel.size() > 0) chk(q_sel.pop_front(), q_exp.pop_front());
  task note(int s, logic [31:0] e);
    q_sel.push_back(s);
    q_exp.push_back(e);
  endtask
  task tick(int k);
    wait (q_sel.size() == 0);
    repeat (k) @(negedge I_CLK);
  endtask
  task cmd(logic [7:0] op, int n = 0);
    tick(1);
    u_smd_host_model.send(op, n, rx);
    repeat (8) @(negedge I_CLK);
  endtask
  task steps(int k);
    tick(1);
    repeat (k) begin
      I_POS_STEP = 1;
      @(negedge I_CLK);
      I_POS_STEP = 0;
      @(negedge I_CLK);
    end
  endtask
  task pulse_done();
    tick(1);
    I_TARGET_REACHED = 1;
    @(negedge I_CLK);
    I_TARGET_REACHED = 0;
    tick(4);
  endtask
  // main sequence
  initial begin
    int p, sv, fl, n, er;
    seed = 32'hce8b;
    I_DECEL = $random(seed);
    fl = 8 + ($random(seed) & 15);
    I_SPEED_FLOOR = fl;
    p = 0;
    sv = 0;
    er = 0;
    repeat (10) @(negedge I_CLK);
    I_RST = 0;
    tick(3);
    note(8, 1); // power-up flags
    note(7, 0); // bridges off at power-up
    cmd(8'hb8); note(7, 1);
    note(0, 0); // no motion
    cmd(8'hc0); note(13, 0); // bridges on
    tick(1);
    I_WARN_SET = 16'h8000;
    @(negedge I_CLK);
    I_WARN_SET = 0;
    tick(3); note(9, 1);
    cmd(8'hd0, 2); note(16, 16'h8000);
    note(8, 0);
    note(9, 0);
    for (int k = 0; k < 3; k++) begin
      tick(1);
      I_LOW_SPEED_OPT = (k == 1);
      I_MIN_SPEED = (k == 0) ? fl - 1 : fl + 2;
      cmd({4'h9, k[0], 2'b01, k[0]}); note(0, 1);
      I_MOTOR_STOPPED = 0;
      note(1, k & 1);
      note(2, (k == 2) ? fl + 2 : fl);
      n = 1 + ($random(seed) & 7);
      steps(n);
      p += n;
      cmd(8'h70); note(10, ++er);
      tick(1);
      I_SWITCH_N = 1;
      tick(6);
      if (k[0]) sv = p;
      else p = 0;
      note(4, p);
      note(5, sv);
      note(3, 0);
      tick(1);
      I_MOTOR_STOPPED = 1;
      I_SWITCH_N = 0;
      tick(4); note(3, 1);
    end
    steps(3);
    cmd(8'h70); note(11, 1);
    note(6, 0);
    cmd(8'h78); note(10, ++er);
    pulse_done(); note(3, 1);
    cmd(8'h78); note(11, 2);
    note(6, sv);
    pulse_done(); note(3, 1);
    cmd(8'hd8); note(4, 0);
    tick(1);
    I_MOTOR_STOPPED = 0;
    cmd(8'hb0); note(14, 1);
    note(15, I_DECEL);
    note(3, 0);
    n = n_stop;
    cmd(8'hb8); note(12, n + 1);
    tick(1);
    I_MOTOR_STOPPED = 1;
    tick(4); note(3, 1);
    cmd(8'ha0); note(7, 0);
    note(8, 1);
    cmd(8'hd0, 2); note(16, 1);
    note(8, 1);
    cmd(8'hc0); note(13, 1);
    cmd(8'hb8); note(7, 1);
    cmd(8'ha8); note(7, 0);
    cmd(8'hb0);
    note(7, 1);
    note(3, 1);
    note(14, 0);
    note(8, 0);
    tick(1);
    I_MOTOR_STOPPED = 0;
    cmd(8'ha0);
    note(14, 1);
    note(7, 1);
    note(3, 0);
    tick(1);
    I_MOTOR_STOPPED = 1;
    tick(4);
    note(7, 0);
    note(8, 1);
    note(14, 0);
    note(3, 1);
    note(10, er);
    tick(2);
    final_report();
  end
endmodule
